// ==== lctrc_pkg.sv ====
// Package: register map, field layout and loss thresholds of the tuning bank
package lctrc_pkg;

   // Register indices (word aligned, so byte address = 4*index)
   localparam logic [5:0] REG_CLK_MUTE_IDX  = 6'h11;
   localparam logic [5:0] REG_RX_TUNE_IDX   = 6'h12;
   localparam logic [7:0] ADDR_CLK_MUTE     = {REG_CLK_MUTE_IDX, 2'b00};
   localparam logic [7:0] ADDR_RX_TUNE      = {REG_RX_TUNE_IDX, 2'b00};

   // Reset values of both registers
   localparam logic [7:0] RST_CLK_MUTE      = 8'h00;
   localparam logic [7:0] RST_RX_TUNE       = 8'h00;

   // Field positions, clock / mute / loss / test register
   localparam int POS_TEST_FLOAT = 0;
   localparam int POS_EXLOSS     = 1;
   localparam int POS_MUTE       = 2;
   localparam int POS_RATE       = 3;
   // Field positions, receive tuning register
   localparam int POS_EQ_GAIN    = 0;
   localparam int POS_SLICER     = 2;

   // Consecutive-zero thresholds before loss of signal is declared
   localparam logic [12:0] LOS_ZEROS_EXT = 13'h1000;         // 4096 bits
   localparam logic [12:0] LOS_ZEROS_T1  = 13'(175 + 75);    // T1/J1
   localparam logic [12:0] LOS_ZEROS_E1  = 13'h0020;         // 32 bits

   // Clock / mute / loss / test register layout
   typedef struct packed {
      logic       reserved_top;                 // Plain storage bit
      logic [2:0] clock_source_sel;             // Stored, steers nothing here
      logic       master_clock_rate_select;     // 0 = E1, 1 = T1/J1
      logic       receive_output_mute;          // Force receive data low
      logic       extended_loss_threshold;      // 4096-zero loss detection
      logic       in_circuit_tristate;          // Float every output pin
   } lctrc_clk_mute_s;

   // Receive tuning register layout
   typedef struct packed {
      logic [1:0] wire_size_sel;                // Stored only
      logic       transmit_on_pin_override;     // Stored only
      logic       termination_pin_override;     // Stored only
      logic       slicer_level_hi;
      logic       slicer_level_lo;
      logic       equalizer_gain_hi;
      logic       equalizer_gain_lo;
   } lctrc_rx_tune_s;

endpackage : lctrc_pkg

// ==== lctrc_top.sv ====
// Module: host control bank for clock rate, receive mute, loss and tuning
`timescale 1ns/1ps

module lctrc_top
   import lctrc_pkg::*;
(
   input  wire logic        clk,             // 40 MHz system clock
   input  wire logic        nrst,            // Asynchronous reset, active low
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Receive path from the slicer / decoder, same clock
   input  wire logic        rx_bit_valid,     // One received bit this cycle
   input  wire logic        rx_pos_in,        // Positive data from decoder
   input  wire logic        rx_neg_in,        // Negative data / violation
   input  wire logic        rx_clk_in,        // Recovered clock level
   // Test pin from the board, active low, asynchronous
   input  wire logic        test_pin_n,
   // Device output pins and their shared enable
   output logic             receive_positive_data_out,
   output logic             receive_negative_data_violation_out,
   output logic             receive_clock_out,
   output logic             receive_loss_of_signal,
   output logic             pins_oe_n,        // Low while pins are driven
   // Analog trims
   output logic             synth_t1_rate,    // 1 = T1/J1 master clock
   output logic             slicer_thr_down,  // Threshold lowered 5%
   output logic             slicer_thr_up,    // Threshold raised 5%
   output logic             eq_cut_1db,       // Equalizer gain minus 1 dB
   output logic             eq_cut_3db        // Equalizer gain minus 3 dB
);

   lctrc_clk_mute_s clk_mute;                 // Register at index 0x11
   lctrc_rx_tune_s  rx_tune;                  // Register at index 0x12
   logic            access;                   // APB access phase seen
   logic            hit_clk_mute;             // Address decode
   logic            hit_rx_tune;
   logic            tpin_s1;                  // Test pin synchroniser
   logic            tpin_s2;
   logic            tpin_s3;
   logic            test_pin_low;             // Filtered test pin level
   logic            tristate;                 // Either test source active
   logic [12:0]     zero_run;                 // Consecutive zero count
   logic [12:0]     los_limit;                // Active loss threshold
   logic [12:0]     next_zero_run;
   logic            rx_one;                   // Mark seen on either rail

   assign access       = psel & penable;
   assign hit_clk_mute = (paddr == ADDR_CLK_MUTE);
   assign hit_rx_tune  = (paddr == ADDR_RX_TUNE);
   assign rx_one       = rx_pos_in | rx_neg_in;
   assign tristate     = clk_mute.in_circuit_tristate | test_pin_low;

   // Wait one cycle in access, then answer; keeps prdata a flop output
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (access && !pready) begin
         pready  <= 1'b1;
         pslverr <= !(hit_clk_mute || hit_rx_tune);
         // Unmapped reads return zero, bits above 7 read zero
         if (hit_clk_mute) begin
            prdata <= {24'h00_0000, clk_mute};
         end else if (hit_rx_tune) begin
            prdata <= {24'h00_0000, rx_tune};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Register writes land only at the edge that completes the transfer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clk_mute <= RST_CLK_MUTE;
         rx_tune  <= RST_RX_TUNE;
      end else if (access && pready && pwrite) begin
         if (hit_clk_mute) begin
            clk_mute <= pwdata[7:0];
         end
         if (hit_rx_tune) begin
            rx_tune <= pwdata[7:0];
         end
      end
   end

   // Test pin: three stages; level changes once stages two and three agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tpin_s1      <= 1'b1;
         tpin_s2      <= 1'b1;
         tpin_s3      <= 1'b1;
         test_pin_low <= 1'b0;
      end else begin
         tpin_s1 <= test_pin_n;
         tpin_s2 <= tpin_s1;
         tpin_s3 <= tpin_s2;
         // Disagreement means the pin is still settling; hold the level
         if (tpin_s2 == tpin_s3) begin
            test_pin_low <= !tpin_s3;
         end
      end
   end

   // Threshold follows the extended bit first, then the line rate
   always_comb begin
      if (clk_mute.extended_loss_threshold) begin
         los_limit = LOS_ZEROS_EXT;
      end else if (clk_mute.master_clock_rate_select) begin
         los_limit = LOS_ZEROS_T1;
      end else begin
         los_limit = LOS_ZEROS_E1;
      end
   end

   // Zero run saturates at the largest threshold so it never wraps
   always_comb begin
      next_zero_run = zero_run;
      if (rx_bit_valid) begin
         if (rx_one) begin
            next_zero_run = 13'h0000;
         end else if (zero_run != LOS_ZEROS_EXT) begin
            next_zero_run = zero_run + 13'h0001;
         end
      end
   end

   // Loss is declared on the threshold and cleared by the next mark;
   // the percentage-of-ones release is left to the analog detector
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         zero_run               <= 13'h0000;
         receive_loss_of_signal <= 1'b0;
      end else begin
         zero_run <= next_zero_run;
         if (rx_bit_valid && rx_one) begin
            receive_loss_of_signal <= 1'b0;
         end else if (next_zero_run >= los_limit) begin
            receive_loss_of_signal <= 1'b1;
         end
      end
   end

   // Receive data pins; mute gates data, never the clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         receive_positive_data_out           <= 1'b0;
         receive_negative_data_violation_out <= 1'b0;
         receive_clock_out                   <= 1'b0;
      end else begin
         receive_positive_data_out <=
            rx_pos_in & !clk_mute.receive_output_mute;
         receive_negative_data_violation_out <=
            rx_neg_in & !clk_mute.receive_output_mute;
         receive_clock_out <= rx_clk_in;
      end
   end

   // Pin enable and trims, one flop each
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pins_oe_n       <= 1'b0;
         synth_t1_rate   <= 1'b0;
         slicer_thr_down <= 1'b0;
         slicer_thr_up   <= 1'b0;
         eq_cut_1db      <= 1'b0;
         eq_cut_3db      <= 1'b0;
      end else begin
         pins_oe_n     <= tristate;
         synth_t1_rate <= clk_mute.master_clock_rate_select;
         // Codes 00 and 11 both leave the trims at normal
         slicer_thr_down <= !rx_tune.slicer_level_hi
                            & rx_tune.slicer_level_lo;
         slicer_thr_up   <= rx_tune.slicer_level_hi
                            & !rx_tune.slicer_level_lo;
         eq_cut_1db      <= !rx_tune.equalizer_gain_hi
                            & rx_tune.equalizer_gain_lo;
         eq_cut_3db      <= rx_tune.equalizer_gain_hi
                            & !rx_tune.equalizer_gain_lo;
      end
   end

   // Checks kept next to the logic they guard
   rate_follows_a: assert property (@(posedge clk) disable iff (!nrst)
      ##1 synth_t1_rate == $past(clk_mute.master_clock_rate_select))
      else $error("synth rate does not follow rate bit");

   mute_data_low_a: assert property (@(posedge clk) disable iff (!nrst)
      $past(clk_mute.receive_output_mute) |->
      !receive_positive_data_out && !receive_negative_data_violation_out)
      else $error("receive data not muted");

   clock_unmuted_a: assert property (@(posedge clk) disable iff (!nrst)
      ##1 receive_clock_out == $past(rx_clk_in))
      else $error("receive clock disturbed");

   ext_loss_limit_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(receive_loss_of_signal) && $past(clk_mute.extended_loss_threshold)
      |-> zero_run >= LOS_ZEROS_EXT)
      else $error("extended loss declared early");

   norm_loss_limit_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(receive_loss_of_signal) && !$past(clk_mute.extended_loss_threshold)
      |-> zero_run >= (($past(clk_mute.master_clock_rate_select))
                       ? LOS_ZEROS_T1 : LOS_ZEROS_E1))
      else $error("normal loss declared early");

   test_float_a: assert property (@(posedge clk) disable iff (!nrst)
      $past(clk_mute.in_circuit_tristate) |-> pins_oe_n)
      else $error("pins driven in test mode");

   test_pin_a: assert property (@(posedge clk) disable iff (!nrst)
      !tpin_s2 && !tpin_s3 ##1 1'b1 ##1 1'b1 |-> pins_oe_n)
      else $error("test pin ignored");

   slicer_code_a: assert property (@(posedge clk) disable iff (!nrst)
      ##1 !(slicer_thr_down && slicer_thr_up) &&
      (slicer_thr_up == ($past(rx_tune.slicer_level_hi) &&
                         !$past(rx_tune.slicer_level_lo))))
      else $error("slicer decode wrong");

   gain_code_a: assert property (@(posedge clk) disable iff (!nrst)
      ##1 eq_cut_1db == (!$past(rx_tune.equalizer_gain_hi) &&
                         $past(rx_tune.equalizer_gain_lo)))
      else $error("gain decode wrong");

   write_back_a: assert property (@(posedge clk) disable iff (!nrst)
      access && pready && pwrite && hit_rx_tune |=>
      rx_tune == $past(pwdata[7:0]))
      else $error("written value not held");

endmodule : lctrc_top

// ==== lctrc_top_bench.sv ====
// Self-checking bench for the clock, mute, loss and tuning control bank
`timescale 1ns/1ps

module lctrc_top_bench
   import lctrc_pkg::*;
;
   logic        clk, nrst;                 // Clock and active-low reset
   logic        psel, penable, pwrite;     // APB request
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;        // rd holds the last read word
   logic        pready, pslverr, err;
   logic        rx_bit_valid, rx_pos_in, rx_neg_in, rx_clk_in, test_pin_n;
   logic        rx_p, rx_n, rx_c, los, oe_n, t1, dn, up, c1, c3;
   logic [15:0] lfsr;                      // Random source, seeded with 15
   int          n_errors, cmp_count, zeros, lim;
   logic [7:0]  reg_cm, reg_rt;            // Model copies of both registers

   lctrc_top i_dut (
      .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_bit_valid(rx_bit_valid),
      .rx_pos_in(rx_pos_in), .rx_neg_in(rx_neg_in), .rx_clk_in(rx_clk_in),
      .test_pin_n(test_pin_n), .receive_positive_data_out(rx_p),
      .receive_negative_data_violation_out(rx_n),
      .receive_clock_out(rx_c), .receive_loss_of_signal(los),
      .pins_oe_n(oe_n), .synth_t1_rate(t1), .slicer_thr_down(dn),
      .slicer_thr_up(up), .eq_cut_1db(c1), .eq_cut_3db(c3));

   // Free-running 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Sixteen-bit shift register feeding random stimulus
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_next

   // One comparison; four-state equality so an unknown matches only an unknown
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // APB master: request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // No cycle count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Register write that also updates the model
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (a == ADDR_CLK_MUTE) reg_cm = d[7:0];
      else reg_rt = d[7:0];
      repeat (2) @(posedge clk);
   endtask : wr

   // Read one register and compare with the model
   task automatic rd_chk(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
      chk("register", {24'h0, (a == ADDR_CLK_MUTE) ? reg_cm : reg_rt}, rd);
      chk("slave error", 32'h0, 32'(err));
   endtask : rd_chk

   // Feed n valid bits, all zeros or all marks on a random rail
   task automatic feed(input int n, input logic mark);
      repeat (n) begin
         @(posedge clk);
         lfsr = lfsr_next(lfsr);
         rx_bit_valid <= 1'b1;
         rx_pos_in    <= mark & lfsr[0];
         rx_neg_in    <= mark & ~lfsr[0];
      end
      @(posedge clk);
      rx_bit_valid <= 1'b0;
      zeros = mark ? 0 : zeros + n;
      repeat (3) @(posedge clk);
   endtask : feed

   // Count summary and the verdict; the only end of the run
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict

   // Watchdog sized well above the longest loss count
   initial begin
      repeat (30000) @(posedge clk);
      n_errors++;
      print_verdict();
   end

   // Main sequence
   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
      {rx_bit_valid, rx_pos_in, rx_neg_in, rx_clk_in} = '0;
      test_pin_n = 1'b1;
      lfsr = 16'h000f;
      {n_errors, cmp_count, zeros} = '0;
      {reg_cm, reg_rt} = '0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      rd_chk(ADDR_CLK_MUTE);
      rd_chk(ADDR_RX_TUNE);
      // Unmapped place is refused and reads zero
      apb(1'b1, 8'h40, 32'hff);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], err});
      // Random round trips, upper write bits ignored
      repeat (4) begin
         lfsr = lfsr_next(lfsr);
         wr(ADDR_RX_TUNE, {lfsr, lfsr});
         wr(ADDR_CLK_MUTE, {16'hffff, lfsr[7:0], lfsr[15:8]});
         rd_chk(ADDR_RX_TUNE);
         rd_chk(ADDR_CLK_MUTE);
      end
      // Every slicer and gain code
      for (int k = 0; k < 16; k++) begin
         wr(ADDR_RX_TUNE,
            32'(k[1:0]) << POS_EQ_GAIN | 32'(k[3:2]) << POS_SLICER);
         chk("level", 32'({k[3:2] == 1, k[3:2] == 2}), 32'({dn, up}));
         chk("gain", 32'({k[1:0] == 1, k[1:0] == 2}), 32'({c1, c3}));
      end
      // Rate select and the three loss thresholds; model counts zeros
      for (int m = 0; m < 3; m++) begin
         lim = (m == 0) ? int'(LOS_ZEROS_E1) :
               (m == 1) ? int'(LOS_ZEROS_T1) : int'(LOS_ZEROS_EXT);
         wr(ADDR_CLK_MUTE,
            32'(m == 1) << POS_RATE | 32'(m == 2) << POS_EXLOSS);
         chk("rate", 32'(m == 1), 32'(t1));
         feed(lim - 1, 1'b0);
         chk("loss early", 32'(zeros >= lim), 32'(los));
         feed(1, 1'b0);
         chk("loss set", 32'(zeros >= lim), 32'(los));
         feed(1, 1'b1);
         chk("loss clear", 32'(zeros >= lim), 32'(los));
      end
      // Mute forces data low, recovered clock keeps following
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_CLK_MUTE, 32'(m[1]) << POS_MUTE);
         rx_pos_in <= 1'b1;
         rx_neg_in <= 1'b1;
         rx_clk_in <= m[0];
         repeat (2) @(posedge clk);
         chk("data", 32'({2{!m[1]}}), 32'({rx_p, rx_n}));
         chk("clock", 32'(m[0]), 32'(rx_c));
      end
      // Test bit and test pin each float the outputs
      wr(ADDR_CLK_MUTE, 32'h1 << POS_TEST_FLOAT);
      chk("float by bit", 32'h1, 32'(oe_n));
      wr(ADDR_CLK_MUTE, 32'h0);
      chk("driven", 32'h0, 32'(oe_n));
      test_pin_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk("float by pin", 32'h1, 32'(oe_n));
      test_pin_n <= 1'b1;
      repeat (6) @(posedge clk);
      chk("pin released", 32'h0, 32'(oe_n));
      print_verdict();
   end
endmodule : lctrc_top_bench
